// ===== core/mbcs_pkg.sv
// Constants for the multi-board clock and trigger sync block
package mbcs_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_COMMAND    = 8'h00;
    localparam logic [7:0]  ADDR_CONFIG     = 8'h04;
    localparam logic [7:0]  ADDR_MASK       = 8'h08;
    localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
    // Command codes
    localparam logic [31:0] CMD_SYNC_DISABLE = 32'h0000_0078;
    localparam logic [31:0] CMD_SYNC_ENABLE  = 32'h0000_0079;
    localparam logic [31:0] CMD_TRIG_MASTER  = 32'h0000_0065;
    localparam logic [31:0] CMD_TRIG_SLAVE   = 32'h0000_006F;
    localparam logic [31:0] CMD_CLK_MASTER   = 32'h0000_0066;
    localparam logic [31:0] CMD_CLK_SLAVE    = 32'h0000_0070;
    // Reset values
    localparam logic [31:0] COMMAND_RESET   = 32'h0000_0000;
    localparam logic [15:0] MASK_RESET      = 16'h0000;
    localparam logic [4:0]  COUNT_RESET     = 5'h01;
    // Config field positions
    localparam int          CFG_STAR_BIT    = 0;
    localparam int          CFG_NOTRIG_BIT  = 1;
    localparam int          CFG_HUB_BIT     = 2;
    localparam int          CFG_ARM_BIT     = 3;
    localparam int          CFG_COUNT_LSB   = 8;
    // Group limits and hub revision
    localparam logic [4:0]  CASCADE_MAX     = 5'h04;
    localparam logic [4:0]  STAR_MAX        = 5'h10;
    localparam logic [3:0]  HUB_OR_MIN_REV  = 4'h4;
    localparam int          HUB_PORTS       = 16;
    // Link start sequencer
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_WAIT = 2'b01,
        LS_RUN  = 2'b11
    } mbcs_link_state_t;
endpackage : mbcs_pkg

// ===== core/mbcs_sync2.sv
// Two flip-flop synchroniser for levels
`timescale 1ns/1ns
module mbcs_sync2 #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else if (en) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : mbcs_sync2

// ===== core/mbcs_pulse_xing.sv
// Toggle crossing for single-cycle events
`timescale 1ns/1ns
module mbcs_pulse_xing (
    // Source side
    input  wire logic src_clk,
    input  wire logic src_rst,
    input  wire logic src_en,
    input  wire logic src_pulse,
    // Destination side
    input  wire logic dst_clk,
    input  wire logic dst_rst,
    input  wire logic dst_en,
    output logic      dst_pulse
);
    logic tgl;
    logic tgl_s;
    logic tgl_d;

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            tgl <= 1'b0;
        end else if (src_en && src_pulse) begin
            tgl <= ~tgl;
        end
    end

    mbcs_sync2 #(.W(1)) u_sync (
        .clk (dst_clk),
        .rst (dst_rst),
        .en  (dst_en),
        .d   (tgl),
        .q   (tgl_s)
    );

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            tgl_d     <= 1'b0;
            dst_pulse <= 1'b0;
        end else if (dst_en) begin
            tgl_d     <= tgl_s;
            dst_pulse <= tgl_s ^ tgl_d;
        end
    end
endmodule : mbcs_pulse_xing

// ===== core/mbcs_top.sv
// Multi-board clock and trigger synchronisation with AHB-Lite registers
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module mbcs_top
    import mbcs_pkg::*;
#(
    parameter int N_HUB = HUB_PORTS
) (
    // Core clock, reset, enable
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Hub revision strap
    input  wire logic [3:0]       hub_rev,
    // Shared sampling clock domain
    input  wire logic             link_clk,
    input  wire logic             local_trig,
    // Trigger line, driven high only when enabled, released otherwise
    input  wire logic             trig_line_in,
    output logic                  trig_line_out,
    output logic                  trig_line_oe_n,
    // Hub inputs from each cabled board
    input  wire logic [N_HUB-1:0] hub_trig_in,
    // Clock source drive enable, low while driving
    output logic                  samp_clk_oe_n,
    // Group start on the sampling clock
    output logic                  group_start
);
    // Core-side registers
    logic [31:0]      board_command;
    logic             sync_en;
    logic             trig_master;
    logic             clk_master;
    logic [31:0]      sync_config;
    logic [15:0]      hub_mask;
    logic [7:0]       start_count;

    // AHB address phase capture
    logic             dp_valid;
    logic             dp_write;
    logic [7:0]       dp_addr;

    // Decode
    wire              ap_take   = hsel && htrans[1] && hready;
    wire  [7:0]       ap_addr   = haddr[7:0];
    wire              wr_cmd    = dp_valid && dp_write && (dp_addr == ADDR_COMMAND);
    wire              wr_cfg    = dp_valid && dp_write && (dp_addr == ADDR_CONFIG);
    wire              wr_mask   = dp_valid && dp_write && (dp_addr == ADDR_MASK);

    // Config fields
    wire              cfg_star   = sync_config[CFG_STAR_BIT];
    wire              cfg_notrig = sync_config[CFG_NOTRIG_BIT];
    wire              cfg_hub    = sync_config[CFG_HUB_BIT];
    wire              cfg_arm    = sync_config[CFG_ARM_BIT];
    wire  [4:0]       cfg_count  = sync_config[CFG_COUNT_LSB +: 5];

    // Strap into core domain
    logic [3:0]       hub_rev_s;

    mbcs_sync2 #(.W(4)) u_rev_sync (
        .clk (core_clk),
        .rst (sys_rst),
        .en  (clk_en),
        .d   (hub_rev),
        .q   (hub_rev_s)
    );

    // Group checks
    wire  [4:0]       group_max  = cfg_star ? STAR_MAX : CASCADE_MAX;
    wire              group_ok   = (cfg_count != 5'h00) && (cfg_count <= group_max);
    wire              or_ok      = cfg_star && (hub_rev_s >= HUB_OR_MIN_REV);
    wire  [15:0]      mask_less1 = hub_mask - 16'h0001;
    wire              multi_mstr = |(hub_mask & mask_less1);
    wire              or_refused = multi_mstr && !or_ok;
    wire              link_run_s;

    // Status word
    wire  [31:0]      status_word = {16'h0000, start_count, 1'b0, link_run_s, or_refused,
                                     group_ok, or_ok, clk_master, trig_master, sync_en};

    // Read mux
    wire  [31:0]      rd_mux = (ap_addr == ADDR_COMMAND) ? board_command :
                               (ap_addr == ADDR_CONFIG)  ? sync_config   :
                               (ap_addr == ADDR_MASK)    ? {16'h0000, hub_mask} :
                               (ap_addr == ADDR_STATUS)  ? status_word   : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // AHB phases
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else if (clk_en) begin
            dp_valid <= ap_take;
            dp_write <= hwrite;
            dp_addr  <= ap_addr;
            if (ap_take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Command decode
    wire              cmd_sync_off  = wr_cmd && (hwdata == CMD_SYNC_DISABLE);
    wire              cmd_sync_on   = wr_cmd && (hwdata == CMD_SYNC_ENABLE);
    wire              cmd_trig_mstr = wr_cmd && (hwdata == CMD_TRIG_MASTER);
    wire              cmd_trig_slv  = wr_cmd && (hwdata == CMD_TRIG_SLAVE);
    wire              cmd_clk_mstr  = wr_cmd && (hwdata == CMD_CLK_MASTER);
    wire              cmd_clk_slv   = wr_cmd && (hwdata == CMD_CLK_SLAVE);

    // Command register, unknown codes kept for readback
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            board_command <= COMMAND_RESET;
        end else if (clk_en && wr_cmd) begin
            board_command <= hwdata;
        end
    end

    // Synchronisation enable
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_en <= 1'b1;
        end else if (clk_en) begin
            if (cmd_sync_off) begin
                sync_en <= 1'b0;
            end else if (cmd_sync_on) begin
                sync_en <= 1'b1;
            end
        end
    end

    // Trigger master role
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trig_master <= 1'b0;
        end else if (clk_en) begin
            if (cmd_trig_mstr) begin
                trig_master <= 1'b1;
            end else if (cmd_trig_slv) begin
                trig_master <= 1'b0;
            end
        end
    end

    // Clock source role
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_master <= 1'b0;
        end else if (clk_en) begin
            if (cmd_clk_mstr) begin
                clk_master <= 1'b1;
            end else if (cmd_clk_slv) begin
                clk_master <= 1'b0;
            end
        end
    end

    // Config and hub mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_config <= {19'h00000, COUNT_RESET, 8'h00};
            hub_mask    <= MASK_RESET;
        end else if (clk_en) begin
            if (wr_cfg) begin
                sync_config <= {19'h00000, hwdata[CFG_COUNT_LSB +: 5], 4'h0, hwdata[3:0]};
            end
            if (wr_mask) begin
                hub_mask <= hwdata[15:0];
            end
        end
    end

    // Reset and enable into the link domain
    logic             link_rst;
    logic             link_en;

    mbcs_sync2 #(.W(2)) u_ctl_sync (
        .clk (link_clk),
        .rst (1'b0),
        .en  (1'b1),
        .d   ({sys_rst, clk_en}),
        .q   ({link_rst, link_en})
    );

    // Quasi-static settings into the link domain
    localparam int CW = 8 + N_HUB;
    logic [CW-1:0]    cfg_l;
    wire  [CW-1:0]    cfg_c = {hub_mask[N_HUB-1:0], sync_en && group_ok, trig_master, clk_master,
                               cfg_star, cfg_notrig, cfg_hub, or_ok, cfg_arm};

    mbcs_sync2 #(.W(CW)) u_cfg_sync (
        .clk (link_clk),
        .rst (link_rst),
        .en  (link_en),
        .d   (cfg_c),
        .q   (cfg_l)
    );

    wire              l_arm    = cfg_l[0];
    wire              l_or_ok  = cfg_l[1];
    wire              l_hub    = cfg_l[2];
    wire              l_notrig = cfg_l[3];
    wire              l_star   = cfg_l[4];
    wire              l_clkm   = cfg_l[5];
    wire              l_trigm  = cfg_l[6];
    wire              l_active = cfg_l[7];
    wire  [N_HUB-1:0] l_mask   = cfg_l[CW-1:8];

    // Pins into the link domain
    logic             trig_line_s;
    logic [N_HUB-1:0] hub_trig_s;

    mbcs_sync2 #(.W(N_HUB + 1)) u_pin_sync (
        .clk (link_clk),
        .rst (link_rst),
        .en  (link_en),
        .d   ({hub_trig_in, trig_line_in}),
        .q   ({hub_trig_s, trig_line_s})
    );

    // Hub trigger combining
    wire  [N_HUB-1:0] hub_sel   = hub_trig_s & l_mask;
    wire  [N_HUB-1:0] mask_low  = l_mask & (~l_mask + {{(N_HUB-1){1'b0}}, 1'b1});
    wire              hub_one   = |(hub_trig_s & mask_low);
    wire              hub_any   = |hub_sel;
    wire              hub_comb  = l_or_ok ? hub_any : hub_one;
    wire              hub_role  = l_star && l_hub;

    // Own trigger, or combined hub trigger in hub role, onto the line
    wire              send_trig = hub_role ? hub_comb : (l_trigm && local_trig);
    wire              drive     = l_active && !l_notrig && send_trig;

    // Source of this board's start
    wire              bus_trig  = hub_role ? hub_comb : trig_line_s;
    wire              use_group = l_active && !l_notrig;
    wire              grp_trig  = use_group ? bus_trig : local_trig;
    wire              trig_rise;

    // Link sequencer
    mbcs_link_state_t ls;
    mbcs_link_state_t next_ls;
    logic             trig_q;

    assign trig_rise = grp_trig && !trig_q;

    always_comb begin
        next_ls = ls;
        unique case (ls)
            LS_IDLE: if (l_arm) next_ls = LS_WAIT;
            LS_WAIT: begin
                if (!l_arm) begin
                    next_ls = LS_IDLE;
                end else if (trig_rise) begin
                    next_ls = LS_RUN;
                end
            end
            LS_RUN:  if (!l_arm) next_ls = LS_IDLE;
            default: next_ls = LS_IDLE;
        endcase
    end

    // Start registered on the sampling clock
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ls          <= LS_IDLE;
            trig_q      <= 1'b0;
            group_start <= 1'b0;
        end else if (link_en) begin
            ls          <= next_ls;
            trig_q      <= grp_trig;
            group_start <= (ls == LS_WAIT) && l_arm && trig_rise;
        end
    end

    // Line and clock drivers
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            trig_line_oe_n <= 1'b1;
            samp_clk_oe_n  <= 1'b1;
        end else if (link_en) begin
            trig_line_oe_n <= !drive;
            samp_clk_oe_n  <= !(l_active && l_clkm);
        end
    end

    assign trig_line_out = 1'b1;

    // Run state and start count back to core
    wire              start_core;

    mbcs_sync2 #(.W(1)) u_run_sync (
        .clk (core_clk),
        .rst (sys_rst),
        .en  (clk_en),
        .d   (ls == LS_RUN),
        .q   (link_run_s)
    );

    mbcs_pulse_xing u_start_xing (
        .src_clk   (link_clk),
        .src_rst   (link_rst),
        .src_en    (link_en),
        .src_pulse (group_start),
        .dst_clk   (core_clk),
        .dst_rst   (sys_rst),
        .dst_en    (clk_en),
        .dst_pulse (start_core)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            start_count <= 8'h00;
        end else if (clk_en && start_core) begin
            start_count <= start_count + 8'h01;
        end
    end
endmodule : mbcs_top

// ===== sim/mbcs_chk.sv
// Port checker for the multi-board sync block
`timescale 1ns/1ns
module mbcs_chk
    import mbcs_pkg::*;
#(
    parameter int N_HUB = HUB_PORTS
) (
    // Core side
    input wire logic             core_clk,
    input wire logic             sys_rst,
    input wire logic             clk_en,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [2:0]       hsize,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [3:0]       hub_rev,
    // Link side
    input wire logic             link_clk,
    input wire logic             local_trig,
    input wire logic             trig_line_in,
    input wire logic             trig_line_out,
    input wire logic             trig_line_oe_n,
    input wire logic [N_HUB-1:0] hub_trig_in,
    input wire logic             samp_clk_oe_n,
    input wire logic             group_start
);
    logic        dp_on;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] cmd_copy;
    logic [7:0]  trig_hist;
    wire         take     = hsel && htrans[1] && hready && clk_en;
    wire         any_trig = local_trig || trig_line_in || (|hub_trig_in);
    wire         cmd_wr   = dp_on && dp_wr && dp_addr == ADDR_COMMAND;
    wire         rd_dp    = dp_on && !dp_wr;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dp_on    <= 1'b0;
            dp_wr    <= 1'b0;
            dp_addr  <= 8'h00;
            cmd_copy <= COMMAND_RESET;
        end else begin
            dp_on   <= take;
            dp_wr   <= hwrite;
            dp_addr <= haddr[7:0];
            if (cmd_wr) begin
                cmd_copy <= hwdata;
            end
        end
    end
    // Recent trigger activity from any source
    always_ff @(posedge link_clk) begin
        if (sys_rst) begin
            trig_hist <= 8'h00;
        end else begin
            trig_hist <= {trig_hist[6:0], any_trig};
        end
    end
    a_bus_okay: assert property (@(posedge core_clk) disable iff (sys_rst) hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> hrdata == 32'h0 && samp_clk_oe_n && trig_line_oe_n)
        else $error("outputs not idle after reset");
    a_cmd_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
        rd_dp && dp_addr == ADDR_COMMAND |-> hrdata == cmd_copy)
        else $error("command readback differs from last write");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        rd_dp && dp_addr > ADDR_STATUS |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_nosync_release: assert property (@(posedge core_clk) disable iff (sys_rst)
        cmd_wr && hwdata == CMD_SYNC_DISABLE |-> ##[1:60] (samp_clk_oe_n && trig_line_oe_n))
        else $error("drives kept after sync disable");
    a_start_pulse: assert property (@(posedge link_clk) disable iff (sys_rst)
        group_start |=> !group_start [*4])
        else $error("group start longer than one cycle");
    a_start_cause: assert property (@(posedge link_clk) disable iff (sys_rst)
        group_start |-> |trig_hist)
        else $error("group start without trigger");
    a_drive_cause: assert property (@(posedge link_clk) disable iff (sys_rst)
        !trig_line_oe_n |-> |trig_hist)
        else $error("trigger line driven without trigger");
    c_start: cover property (@(posedge link_clk) disable iff (sys_rst) group_start);
    c_clock_drive: cover property (@(posedge link_clk) disable iff (sys_rst) !samp_clk_oe_n);
    c_nosync: cover property (@(posedge core_clk) disable iff (sys_rst) cmd_wr && hwdata == CMD_SYNC_DISABLE);
endmodule : mbcs_chk

bind mbcs_top mbcs_chk #(.N_HUB(N_HUB)) u_chk (.*);

// ===== sim/mbcs_peer.sv
// Model of the other boards on the trigger line and hub cables
`timescale 1ns/1ns
module mbcs_peer #(
    parameter int N = 16
) (
    // Sampling clock
    input wire logic         link_clk,
    // Bench controls
    input wire logic         peer_fire,
    input wire logic [N-1:0] peer_hub,
    // Board pins
    input wire logic         trig_line_out,
    input wire logic         trig_line_oe_n,
    output logic             trig_line,
    output logic [N-1:0]     hub_trig
);
    logic peer_drive;
    // Peers follow the shared clock and never drive it
    always_ff @(posedge link_clk) begin
        peer_drive <= peer_fire;
        hub_trig   <= peer_hub;
    end
    // Wired line with pull-down
    assign trig_line = peer_drive || (!trig_line_oe_n && trig_line_out);
endmodule : mbcs_peer

// ===== sim/test_multi_board_clock_trigger_sync.sv
// Self-checking bench for the multi-board sync block
`timescale 1ns/1ns
module test_multi_board_clock_trigger_sync
    import mbcs_pkg::*;
;
    logic        core_clk   = 1'b0;
    logic        link_clk   = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'b00;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic [3:0]  hub_rev    = 4'h4;
    logic        local_trig = 1'b0;
    logic        peer_fire  = 1'b0;
    logic [15:0] peer_hub   = 16'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        trig_line;
    logic        trig_line_out;
    logic        trig_line_oe_n;
    logic [15:0] hub_trig;
    logic        samp_clk_oe_n;
    logic        group_start;
    logic [31:0] rdata;
    int          miscompares = 0;
    int          num_checks  = 0;
    mbcs_top #(.N_HUB(16)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .hub_rev(hub_rev), .link_clk(link_clk),
        .local_trig(local_trig), .trig_line_in(trig_line), .trig_line_out(trig_line_out),
        .trig_line_oe_n(trig_line_oe_n), .hub_trig_in(hub_trig), .samp_clk_oe_n(samp_clk_oe_n),
        .group_start(group_start));
    mbcs_peer #(.N(16)) u_peer (.link_clk(link_clk), .peer_fire(peer_fire), .peer_hub(peer_hub),
        .trig_line_out(trig_line_out), .trig_line_oe_n(trig_line_oe_n), .trig_line(trig_line), .hub_trig(hub_trig));
    initial forever #5 core_clk = ~core_clk;
    initial begin
        #3;
        forever begin
            #62 link_clk = ~link_clk;
            #63 link_clk = ~link_clk;
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            miscompares++;
            finish_test();
        end
    endtask : bus_wait
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, addr};
        bus_wait();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        bus_wait();
        rdata = hrdata;
    endtask : xfer
    task automatic rd_check(input string name, input logic [7:0] addr, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, addr, 32'h0);
        check(name, rdata & m, e);
    endtask : rd_check
    task automatic wait_link(input int n);
        repeat (n) @(posedge link_clk);
        @(posedge core_clk);
    endtask : wait_link
    task automatic rearm(input logic [31:0] cfg);
        xfer(1'b1, ADDR_CONFIG, cfg & 32'hFFFF_FFF7);
        wait_link(4);
        xfer(1'b1, ADDR_CONFIG, cfg);
        wait_link(4);
    endtask : rearm
    // Kind 0 local, 1 peer on line, 2 hub cables
    task automatic fire(input string name, input int kind, input logic [15:0] hub, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge link_clk);
        local_trig <= (kind == 0);
        peer_fire  <= (kind == 1);
        peer_hub   <= (kind == 2) ? hub : 16'h0;
        for (int i = 0; i < 24; i++) begin
            @(posedge link_clk);
            if (group_start === 1'b1) seen = 1'b1;
            if (i == 6) begin
                local_trig <= 1'b0;
                peer_fire  <= 1'b0;
                peer_hub   <= 16'h0;
            end
        end
        check(name, {31'h0, seen}, {31'h0, exp});
        @(posedge core_clk);
    endtask : fire
    task automatic t_reset;
        check("reset oe_n", {30'h0, samp_clk_oe_n, trig_line_oe_n}, 32'h3);
        rd_check("command", ADDR_COMMAND, 32'hFFFF_FFFF, COMMAND_RESET);
        rd_check("config", ADDR_CONFIG, 32'hFFFF_FFFF, {19'h0, COUNT_RESET, 8'h00});
        rd_check("mask", ADDR_MASK, 32'hFFFF_FFFF, {16'h0, MASK_RESET});
        rd_check("status", ADDR_STATUS, 32'h7F, 32'h11);
        xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        rd_check("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_cascade;
        rearm(32'h0000_0408);
        xfer(1'b1, ADDR_COMMAND, CMD_CLK_MASTER);
        xfer(1'b1, ADDR_COMMAND, CMD_TRIG_MASTER);
        wait_link(4);
        check("clock drive", {31'h0, samp_clk_oe_n}, 32'h0);
        rd_check("status", ADDR_STATUS, 32'h17, 32'h17);
        fire("local start", 0, 16'h0, 1'b1);
        rd_check("running", ADDR_STATUS, 32'h40, 32'h40);
        rd_check("command", ADDR_COMMAND, 32'hFFFF_FFFF, CMD_TRIG_MASTER);
        rearm(32'h0000_0508);
        rd_check("size 5", ADDR_STATUS, 32'h10, 32'h0);
        check("size 5 clock", {31'h0, samp_clk_oe_n}, 32'h1);
        fire("size 5 line", 1, 16'h0, 1'b0);
        $display("test cascade done");
    endtask : t_cascade
    task automatic t_star;
        hub_rev <= 4'h4;
        xfer(1'b1, ADDR_MASK, 32'h0000_0003);
        rearm(32'h0000_100D);
        rd_check("or allowed", ADDR_STATUS, 32'h38, 32'h18);
        fire("hub or", 2, 16'h0002, 1'b1);
        hub_rev <= 4'h3;
        rearm(32'h0000_100D);
        rd_check("or refused", ADDR_STATUS, 32'h38, 32'h30);
        fire("hub 1 alone", 2, 16'h0002, 1'b0);
        fire("hub 0", 2, 16'h0001, 1'b1);
        rearm(32'h0000_110D);
        rd_check("size 17", ADDR_STATUS, 32'h10, 32'h0);
        $display("test star done");
    endtask : t_star
    task automatic t_clock_only;
        xfer(1'b1, ADDR_COMMAND, CMD_TRIG_SLAVE);
        rearm(32'h0000_040A);
        fire("line ignored", 1, 16'h0, 1'b0);
        check("line free", {31'h0, trig_line_oe_n}, 32'h1);
        fire("local used", 0, 16'h0, 1'b1);
        $display("test clock only done");
    endtask : t_clock_only
    task automatic t_nosync;
        rearm(32'h0000_0408);
        fire("peer start", 1, 16'h0, 1'b1);
        rearm(32'h0000_0408);
        xfer(1'b1, ADDR_COMMAND, CMD_SYNC_DISABLE);
        wait_link(4);
        check("released", {30'h0, samp_clk_oe_n, trig_line_oe_n}, 32'h3);
        rd_check("disable code", ADDR_COMMAND, 32'hFFFF_FFFF, 32'd120);
        rd_check("sync off", ADDR_STATUS, 32'h1, 32'h0);
        fire("peer ignored", 1, 16'h0, 1'b0);
        fire("alone", 0, 16'h0, 1'b1);
        xfer(1'b1, ADDR_COMMAND, CMD_SYNC_ENABLE);
        rd_check("sync on", ADDR_STATUS, 32'h1, 32'h1);
        $display("test nosync done");
    endtask : t_nosync
    initial begin
        repeat (4) @(posedge link_clk);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_link(3);
        t_reset();
        t_cascade();
        t_star();
        t_clock_only();
        t_nosync();
        finish_test();
    end
endmodule : test_multi_board_clock_trigger_sync
